// ### rtl/flim_cfg.svh
// Constants for the fiber link integrity monitor
`ifndef FLIM_CFG_SVH
`define FLIM_CFG_SVH
`define FLIM_CLK_HZ         40000000
`define FLIM_BIT_NS         100
`define FLIM_CLK_NS         25
`define FLIM_LOW_BITS       2000
`define FLIM_LOW_CYC        ((`FLIM_LOW_BITS * `FLIM_BIT_NS) / `FLIM_CLK_NS)
`define FLIM_GOOD_MS        360
`define FLIM_GOOD_CYC       ((`FLIM_GOOD_MS * (`FLIM_CLK_HZ / 1000)))
`define FLIM_COL_HALF_CYC   2
`define FLIM_SQ_NS          20
`define FLIM_SQ_CYC         ((`FLIM_SQ_NS + `FLIM_CLK_NS - 1) / `FLIM_CLK_NS)
`define FLIM_CNT_W          24
`define FLIM_FIFO_DEPTH     8
`define FLIM_FIFO_AW        3
`endif

// ### rtl/flim_pkg.sv
// Types for the fiber link integrity monitor
package flim_pkg;
  typedef enum logic [1:0] {
    FLIM_PASS,
    FLIM_FAIL,
    FLIM_QUAL
  } flim_state_type;
endpackage

// ### rtl/flim_fifo.sv
// Small flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module flim_fifo #(
  parameter int WIDTH = 2,
  parameter int DEPTH = 8,
  parameter int AW    = 3
) (
  input  wire logic             clk_sys_in,
  input  wire logic             srst_in,
  input  wire logic [WIDTH-1:0] wr_data_in,
  input  wire logic             wr_valid_in,
  output logic                  wr_ready_out,
  output logic [WIDTH-1:0]      rd_data_out,
  output logic                  rd_valid_out,
  input  wire logic             rd_ready_in
);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_ptr_q;
  logic [AW-1:0]    rd_ptr_q;
  logic [AW:0]      count_q;
  logic             push;
  logic             pop;

  // Count is one bit wider than the pointers so a full FIFO is told apart from an empty one
  assign wr_ready_out = (count_q != (AW+1)'(DEPTH));
  assign rd_valid_out = (count_q != '0);
  assign push         = wr_valid_in && wr_ready_out;
  assign pop          = rd_valid_out && rd_ready_in;
  assign rd_data_out  = mem_q[rd_ptr_q];

  always_ff @(posedge clk_sys_in)
  begin
    if (push)
    begin
      mem_q[wr_ptr_q] <= wr_data_in;
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_q <= (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + AW'(1);
      end
      if (pop)
      begin
        rd_ptr_q <= (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + AW'(1);
      end
      count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // flim_fifo
`default_nettype wire

// ### rtl/flim_squelch.sv
// Transmit squelch: qualifies input activity by minimum pulse width
`timescale 1ns/1ps
`default_nettype none
`include "flim_cfg.svh"
module flim_squelch (
  input  wire logic clk_sys_in,
  input  wire logic srst_in,
  input  wire logic tx_act_in,
  input  wire logic tx_data_in,
  output logic      tx_qual_out,
  output logic      tx_data_out
);
  logic [3:0] wid_q;

  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in)
    begin
      wid_q       <= 4'h0;
      tx_qual_out <= 1'b0;
      tx_data_out <= 1'b0;
    end
    else
    begin
      if (!tx_act_in)
      begin
        wid_q       <= 4'h0;
        tx_qual_out <= 1'b0;
      end
      else if (wid_q < 4'(`FLIM_SQ_CYC))
      begin
        wid_q <= wid_q + 4'h1;
      end
      else
      begin
        tx_qual_out <= 1'b1;
      end
      tx_data_out <= tx_data_in;
    end
  end
endmodule // flim_squelch
`default_nettype wire

// ### rtl/flim_monitor.sv
// Fiber link integrity monitor top level
`timescale 1ns/1ps
`default_nettype none
`include "flim_cfg.svh"
module flim_monitor #(
  parameter int LOW_CYC  = `FLIM_LOW_CYC,
  parameter int GOOD_CYC = `FLIM_GOOD_CYC
) (
  input  wire logic clk_sys_in,
  input  wire logic srst_in,
  input  wire logic light_ok_in,
  input  wire logic tx_act_in,
  input  wire logic tx_data_in,
  input  wire logic rx_act_in,
  input  wire logic rx_data_in,
  input  wire logic loopback_dis_in,
  input  wire logic sqe_test_req_in,
  output logic      led_drive_out,
  output logic      led_active_out,
  output logic      aui_rx_p_out,
  output logic      aui_rx_n_out,
  output logic      aui_col_p_out,
  output logic      aui_col_n_out,
  output logic      link_monitor_indicator_out,
  output logic      link_fail_state_out,
  output logic      fifo_overrun_out
);
  flim_pkg::flim_state_type state_q;
  logic [`FLIM_CNT_W-1:0]  low_cnt_q;
  logic [`FLIM_CNT_W-1:0]  good_cnt_q;
  logic                    low_expired;
  logic                    good_expired;
  logic                    tx_qual;
  logic                    tx_sq_data;
  logic                    link_ok;
  logic                    tx_go;
  logic                    rx_go;
  logic                    lb_go;
  logic                    col_go;
  logic [1:0]              fifo_out;
  logic                    fifo_valid;
  logic                    fifo_wr_ready;
  logic [1:0]              col_div_q;
  logic                    col_sq_q;

  flim_squelch u_squelch (
    .clk_sys_in  (clk_sys_in),
    .srst_in     (srst_in),
    .tx_act_in   (tx_act_in),
    .tx_data_in  (tx_data_in),
    .tx_qual_out (tx_qual),
    .tx_data_out (tx_sq_data)
  );

  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in || light_ok_in)
    begin
      low_cnt_q <= '0;
    end
    else if (!low_expired)
    begin
      low_cnt_q <= low_cnt_q + `FLIM_CNT_W'(1);
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in || !light_ok_in)
    begin
      good_cnt_q <= '0;
    end
    else if (!good_expired)
    begin
      good_cnt_q <= good_cnt_q + `FLIM_CNT_W'(1);
    end
  end

  assign low_expired  = (low_cnt_q > `FLIM_CNT_W'(LOW_CYC));
  assign good_expired = (good_cnt_q >= `FLIM_CNT_W'(GOOD_CYC));

  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in)
    begin
      // Start failed; the link must prove itself
      state_q <= flim_pkg::FLIM_FAIL;
    end
    else
    begin
      case (state_q)
        flim_pkg::FLIM_PASS:
        begin
          if (low_expired)
          begin
            state_q <= flim_pkg::FLIM_FAIL;
          end
        end
        flim_pkg::FLIM_FAIL:
        begin
          if (good_expired)
          begin
            state_q <= flim_pkg::FLIM_QUAL;
          end
        end
        flim_pkg::FLIM_QUAL:
        begin
          // Light lost again before idle restarts qualification
          if (!light_ok_in)
          begin
            state_q <= flim_pkg::FLIM_FAIL;
          end
          else if (!tx_act_in && !rx_act_in)
          begin
            state_q <= flim_pkg::FLIM_PASS;
          end
        end
        default:
        begin
          state_q <= flim_pkg::FLIM_FAIL;
        end
      endcase
    end
  end

  assign link_ok = (state_q == flim_pkg::FLIM_PASS);

  assign tx_go  = link_ok && tx_qual;
  assign rx_go  = link_ok && rx_act_in;
  assign lb_go  = tx_go && !rx_go && !loopback_dis_in;
  assign col_go = link_ok && ((tx_go && rx_go && !loopback_dis_in) || sqe_test_req_in);

  // Receive stream buffered; loss of ready shows as overrun
  flim_fifo #(
    .WIDTH (2),
    .DEPTH (`FLIM_FIFO_DEPTH),
    .AW    (`FLIM_FIFO_AW)
  ) u_fifo (
    .clk_sys_in   (clk_sys_in),
    .srst_in      (srst_in),
    .wr_data_in   ({rx_go || lb_go, rx_go ? rx_data_in : tx_sq_data}),
    .wr_valid_in  (1'b1),
    .wr_ready_out (fifo_wr_ready),
    .rd_data_out  (fifo_out),
    .rd_valid_out (fifo_valid),
    .rd_ready_in  (1'b1)
  );

  // 10 MHz from 40 MHz clock
  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in || !col_go)
    begin
      col_div_q <= 2'h0;
      col_sq_q  <= 1'b0;
    end
    else if (col_div_q == 2'(`FLIM_COL_HALF_CYC - 1))
    begin
      col_div_q <= 2'h0;
      col_sq_q  <= ~col_sq_q;
    end
    else
    begin
      col_div_q <= col_div_q + 2'h1;
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in)
    begin
      aui_rx_p_out <= 1'b0;
      aui_rx_n_out <= 1'b0;
    end
    else
    begin
      // Flag bit marks an active entry
      if (fifo_valid && fifo_out[1])
      begin
        aui_rx_p_out <= fifo_out[0];
        aui_rx_n_out <= ~fifo_out[0];
      end
      else
      begin
        aui_rx_p_out <= 1'b0;
        aui_rx_n_out <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in)
    begin
      aui_col_p_out <= 1'b0;
      aui_col_n_out <= 1'b0;
    end
    else
    begin
      if (col_go)
      begin
        aui_col_p_out <= col_sq_q;
        aui_col_n_out <= ~col_sq_q;
      end
      else
      begin
        aui_col_p_out <= 1'b0;
        aui_col_n_out <= 1'b0;
      end
    end
  end

  // only qualified data to the fiber
  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in)
    begin
      led_active_out <= 1'b0;
      led_drive_out  <= 1'b0;
    end
    else
    begin
      led_active_out <= tx_go;
      // LED dark while squelched, so noise never lights the fiber
      led_drive_out  <= tx_go ? ~tx_sq_data : 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in)
    begin
      link_monitor_indicator_out <= 1'b0;
      link_fail_state_out        <= 1'b1;
      fifo_overrun_out           <= 1'b0;
    end
    else
    begin
      link_monitor_indicator_out <= link_ok;
      link_fail_state_out        <= !link_ok;
      fifo_overrun_out           <= !fifo_wr_ready;
    end
  end
endmodule // flim_monitor
`default_nettype wire

// ### tb/flim_monitor_checker.sv
// Port checker for the link integrity monitor
`timescale 1ns/1ps
`default_nettype none
module flim_monitor_checker #(
  parameter int LOW_CYC  = 8,
  parameter int GOOD_CYC = 20
) (
  input wire logic clk_sys_in,
  input wire logic srst_in,
  input wire logic light_ok_in,
  input wire logic tx_act_in,
  input wire logic led_active_out,
  input wire logic aui_rx_p_out,
  input wire logic aui_rx_n_out,
  input wire logic aui_col_p_out,
  input wire logic link_monitor_indicator_out,
  input wire logic link_fail_state_out
);
  int good_q;
  int tx_q;
  // Run lengths, judged against outputs that lag a cycle
  always_ff @(posedge clk_sys_in)
  begin
    good_q <= (srst_in || !light_ok_in) ? 0 : good_q + 1;
    tx_q   <= (srst_in || !tx_act_in) ? 0 : tx_q + 1;
  end
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (srst_in);
  sequence s_dark;
    !link_fail_state_out && !light_ok_in ##1 (!light_ok_in) [*8];
  endsequence
  sequence s_busy;
    tx_act_in ##1 (tx_act_in && link_fail_state_out);
  endsequence
  chk_dark_fail: assert property (s_dark |-> ##[0:3] link_fail_state_out)
    else $error("no fail after long dark");
  chk_good_hold: assert property ($fell(link_fail_state_out) |-> $past(good_q) >= GOOD_CYC)
    else $error("pass before good light span");
  chk_busy_hold: assert property (s_busy |=> link_fail_state_out)
    else $error("pass while transmit busy");
  chk_fail_quiet: assert property (link_fail_state_out && $past(link_fail_state_out, 4)
    |-> !(aui_rx_p_out || aui_col_p_out || led_active_out))
    else $error("activity in fail state");
  chk_rx_level: assert property ((aui_rx_p_out == aui_rx_n_out) |-> !aui_rx_p_out)
    else $error("receive pair idle level wrong");
  chk_col_wave: assert property (aui_col_p_out ##1 aui_col_p_out |=> !aui_col_p_out)
    else $error("collision high too long");
  chk_tx_squelch: assert property ($rose(led_active_out) |-> $past(tx_q) >= 2)
    else $error("transmit passed unqualified");
  chk_ind_state: assert property (link_monitor_indicator_out != link_fail_state_out)
    else $error("indicator disagrees with state");
endmodule // flim_monitor_checker
bind flim_monitor flim_monitor_checker #(.LOW_CYC(LOW_CYC), .GOOD_CYC(GOOD_CYC)) u_chk (
  .clk_sys_in(clk_sys_in), .srst_in(srst_in), .light_ok_in(light_ok_in), .tx_act_in(tx_act_in),
  .led_active_out(led_active_out), .aui_rx_p_out(aui_rx_p_out), .aui_rx_n_out(aui_rx_n_out),
  .aui_col_p_out(aui_col_p_out), .link_monitor_indicator_out(link_monitor_indicator_out),
  .link_fail_state_out(link_fail_state_out));
`default_nettype wire

// ### tb/flim_aui_host.sv
// Far-side controller model driving the transmit input
`timescale 1ns/1ps
`default_nettype none
module flim_aui_host (
  input  wire logic       clk_sys_in,
  input  wire logic [7:0] frame_len_in,
  input  wire logic       frame_go_in,
  output logic            tx_act_out,
  output logic            tx_data_out
);
  logic [7:0] left_q = 8'h00;
  logic       bit_q  = 1'b0;
  // Data toggles while idle too, so no stale bit looks valid
  always_ff @(posedge clk_sys_in)
  begin
    bit_q  <= !bit_q;
    left_q <= frame_go_in ? frame_len_in : (left_q != 8'h00) ? left_q - 8'h01 : 8'h00;
  end
  assign tx_act_out  = left_q != 8'h00;
  assign tx_data_out = bit_q;
endmodule // flim_aui_host
`default_nettype wire

// ### tb/testbench.sv
// Self-checking bench for the link integrity monitor
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic       clk_sys_in = 1'b0;
  logic       srst_in    = 1'b1;
  logic       light      = 1'b0;
  logic       rx_act     = 1'b0;
  logic       rx_data    = 1'b0;
  logic       sqe        = 1'b0;
  logic       lbdis      = 1'b0;
  logic       go         = 1'b0;
  logic [7:0] len        = 8'h00;
  logic       tx_act, tx_data, led_drv, led_act, rx_p, rx_n, col_p, col_n, ind, fail, ovr;
  int         bad_count       = 0;
  int         samples_checked = 0;
  always #12.5 clk_sys_in = ~clk_sys_in;
  flim_aui_host u_host (.clk_sys_in(clk_sys_in), .frame_len_in(len), .frame_go_in(go),
    .tx_act_out(tx_act), .tx_data_out(tx_data));
  flim_monitor #(.LOW_CYC(8), .GOOD_CYC(20)) u_dut (.clk_sys_in(clk_sys_in), .srst_in(srst_in),
    .light_ok_in(light), .tx_act_in(tx_act), .tx_data_in(tx_data), .rx_act_in(rx_act),
    .rx_data_in(rx_data), .loopback_dis_in(lbdis), .sqe_test_req_in(sqe),
    .led_drive_out(led_drv), .led_active_out(led_act), .aui_rx_p_out(rx_p), .aui_rx_n_out(rx_n),
    .aui_col_p_out(col_p), .aui_col_n_out(col_n), .link_monitor_indicator_out(ind),
    .link_fail_state_out(fail), .fifo_overrun_out(ovr));
  task automatic summarize;
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic cmp(input string name, input logic exp, input logic got);
    samples_checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch %s expected %b seen %b", name, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_in);
  endtask
  task automatic look;
    @(negedge clk_sys_in);
  endtask
  task automatic frame(input logic [7:0] n);
    @(posedge clk_sys_in);
    len <= n;
    go  <= 1'b1;
    @(posedge clk_sys_in);
    go  <= 1'b0;
  endtask
  task automatic rx_step(input logic act, input logic d, input logic p, input logic n);
    @(posedge clk_sys_in);
    rx_act  <= act;
    rx_data <= d;
    cyc(5);
    look();
    cmp("rx_p", p, rx_p);
    cmp("rx_n", n, rx_n);
  endtask
  // Any four consecutive samples of a 2-high 2-low wave hold two highs
  task automatic col_wave(input string name);
    int k;
    int hi;
    hi = 0;
    for (k = 0; k < 4; k++)
    begin
      look();
      hi += (col_p === 1'b1) ? 1 : 0;
      cmp("col_pair", 1'b1, col_p ^ col_n);
    end
    cmp(name, 1'b1, hi == 2);
  endtask
  task automatic t_link_up;
    int i;
    @(posedge clk_sys_in);
    light <= 1'b1;
    cyc(14);
    look();
    cmp("fail_early", 1'b1, fail);
    frame(8'h3C);
    cyc(25);
    look();
    cmp("fail_busy", 1'b1, fail);
    for (i = 0; i < 60 && fail !== 1'b0; i++)
      look();
    cmp("fail_idle", 1'b0, fail);
    cmp("indicator", 1'b1, ind);
  endtask
  task automatic t_paths;
    rx_step(1'b1, 1'b1, 1'b1, 1'b0);
    rx_step(1'b1, 1'b0, 1'b0, 1'b1);
    frame(8'h28);
    cyc(6);
    col_wave("collision");
    rx_step(1'b0, 1'b1, 1'b0, 1'b1);
    cmp("led_active", 1'b1, led_act);
    cmp("led_drive", 1'b0, led_drv);
    look();
    cmp("loop_next", 1'b1, rx_p);
    cyc(40);
    look();
    cmp("rx_idle", 1'b0, rx_p | rx_n);
    @(posedge clk_sys_in);
    sqe <= 1'b1;
    cyc(4);
    col_wave("sqe_wave");
    @(posedge clk_sys_in);
    sqe <= 1'b0;
    frame(8'h01);
    repeat (6)
    begin
      look();
      cmp("squelched", 1'b0, led_act);
      cmp("led_idle", 1'b0, led_drv);
    end
  endtask
  // Loopback switched off: transmit still reaches the fiber, receive pair stays idle
  task automatic t_no_loop;
    @(posedge clk_sys_in);
    lbdis <= 1'b1;
    frame(8'h14);
    cyc(8);
    look();
    cmp("lb_off", 1'b0, rx_p | rx_n);
    cmp("lb_tx", 1'b1, led_act);
    cyc(20);
    @(posedge clk_sys_in);
    lbdis <= 1'b0;
  endtask
  task automatic t_dark;
    @(posedge clk_sys_in);
    light <= 1'b0;
    cyc(8);
    light <= 1'b1;
    cyc(4);
    look();
    cmp("short_dark", 1'b0, fail);
    @(posedge clk_sys_in);
    light  <= 1'b0;
    rx_act <= 1'b1;
    sqe    <= 1'b1;
    cyc(14);
    look();
    cmp("long_dark", 1'b1, fail);
    cmp("indicator", 1'b0, ind);
    cmp("rx_quiet", 1'b0, rx_p | rx_n);
    cmp("col_quiet", 1'b0, col_p | col_n);
  endtask
  initial
  begin
    cyc(5);
    srst_in <= 1'b0;
    look();
    cmp("reset_fail", 1'b1, fail);
    cmp("overrun", 1'b0, ovr);
    t_link_up();
    t_paths();
    t_no_loop();
    t_dark();
    summarize();
  end
  initial
  begin
    cyc(3000);
    bad_count++;
    summarize();
  end
endmodule // testbench
`default_nettype wire
